// ### src/ldd_pkg.sv
// Constants, field layout and state encodings for the LED driver diagnostic flags
package ldd_pkg;

  // ****************************************
  // Register offsets and field positions
  // ****************************************
  localparam logic [6:0] ADDR_UPD_REQ   = 7'h06;
  localparam logic [6:0] ADDR_HEAD_LIVE = 7'h35;
  localparam logic [6:0] ADDR_TOG_NVM   = 7'h36;
  localparam int         NCH            = 3;
  localparam int         HL_HEAD_LSB    = 0;
  localparam int         HL_LIVE_LSB    = 3;
  localparam int         TN_TOG_LSB     = 0;
  localparam int         TN_DONE_BIT    = 3;
  localparam int         TN_REJ_BIT     = 4;
  localparam int         TN_ONE_BIT     = 6;
  localparam logic [7:0] RDATA_RST      = 8'h00;
  localparam logic [2:0] CH_FLAGS_RST   = 3'h0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ     = 40_000_000;
  localparam int T_START_MS = 12;
  localparam int T_RUN_MS   = 1;
  localparam int T_GATE_MS  = 1;
  localparam int START_CYC  = (T_START_MS * CLK_HZ + 999) / 1000;
  localparam int RUN_CYC    = (T_RUN_MS * CLK_HZ + 999) / 1000;
  localparam int GATE_CYC   = (T_GATE_MS * CLK_HZ + 999) / 1000;
  localparam int TMR_W      = 20;
  localparam logic [TMR_W-1:0] TMR_RST = 20'h00000;

  // ****************************************
  // Gate-drive supply states
  // ****************************************
  typedef enum logic [4:0] {
    GS_OFF   = 5'b00001,
    GS_START = 5'b00010,
    GS_GOOD  = 5'b00100,
    GS_SAG   = 5'b01000,
    GS_FAULT = 5'b10000
  } ldd_gs_e;

endpackage

// ### src/ldd_chan_if.sv
// Per-channel signal bundle between the flag block and a channel slice
`timescale 1ns/1ps
`default_nettype none
interface ldd_chan_if;
  logic pwm;
  logic reached;
  logic headroom;
  logic gate_high;
  logic chan_on;
  logic uv_ok;
  logic req;
  logic clr_head;
  logic clr_tog;
  logic toggle;
  logic live;
  logic latched;
  logic lowhead;
  logic pull_low;

  modport top  (output pwm, reached, headroom, gate_high, chan_on, uv_ok, req, clr_head, clr_tog,
                input  toggle, live, latched, lowhead, pull_low);
  modport chan (input  pwm, reached, headroom, gate_high, chan_on, uv_ok, req, clr_head, clr_tog,
                output toggle, live, latched, lowhead, pull_low);
endinterface
`default_nettype wire

// ### src/ldd_chan.sv
// One channel slice: toggle, current-reached and headroom flags
`timescale 1ns/1ps
`default_nettype none
module ldd_chan
  import ldd_pkg::*;
#(
  parameter int GATE_LIM = GATE_CYC
) (
  input wire logic   clk,
  input wire logic   rst_n,
  input wire logic   clk_en,
  ldd_chan_if.chan   bus
);

  logic             pwm_prev_reg;
  logic             toggle_reg;
  logic             live_reg;
  logic             latched_reg;
  logic             head_reg;
  logic             head_last_reg;
  logic             pull_reg;
  logic [TMR_W-1:0] gate_cnt_reg;

  // ****************************************
  // Event decode
  // ****************************************
  wire pwm_fall     = pwm_prev_reg & ~bus.pwm;
  wire pwm_change   = pwm_prev_reg ^ bus.pwm;
  wire monitor      = bus.chan_on & bus.uv_ok;
  wire head_event   = monitor & bus.headroom;                       // [RULE15]
  // Off or undervoltage: last sample may re-raise a cleared flag
  wire head_set     = monitor ? bus.headroom : head_last_reg;      // [RULE17]
  wire gate_timeout = gate_cnt_reg >= TMR_W'(GATE_LIM);
  wire live_set     = bus.reached & bus.pwm;                        // [RULE18]
  wire live_clr     = pwm_fall | ~bus.uv_ok | bus.req | gate_timeout; // [RULE19]
  wire lat_clr      = ~bus.uv_ok | head_event;                      // [RULE10]
  wire lat_upd      = pwm_fall | bus.req;                           // [RULE9] [RULE11]

  assign bus.toggle   = toggle_reg;
  assign bus.live     = live_reg;
  assign bus.latched  = latched_reg;
  assign bus.lowhead  = head_reg;
  assign bus.pull_low = pull_reg;

  // Gate-high watchdog, saturating so it never wraps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_cnt_reg <= TMR_RST;
    end else if (clk_en) begin
      if (!(bus.gate_high && bus.pwm)) gate_cnt_reg <= TMR_RST;
      else if (!gate_timeout) gate_cnt_reg <= gate_cnt_reg + 1'b1;
    end
  end

  // Flags; a set wins over a coincident clear, but a latched clear beats an update
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_prev_reg  <= 1'b0;
      toggle_reg    <= 1'b0;
      live_reg      <= 1'b0;
      latched_reg   <= 1'b0;
      head_reg      <= 1'b0;
      head_last_reg <= 1'b0;
      pull_reg      <= 1'b0;
    end else if (clk_en) begin
      pwm_prev_reg <= bus.pwm;
      toggle_reg   <= pwm_change | (toggle_reg & ~bus.clr_tog);     // [RULE14] [RULE22]
      live_reg     <= live_set | (live_reg & ~live_clr);            // [RULE18] [RULE19]
      if (lat_clr) latched_reg <= 1'b0;                             // [RULE10]
      else if (lat_upd) latched_reg <= live_reg;                    // [RULE9] [RULE11]
      head_reg     <= head_set | (head_reg & ~bus.clr_head);        // [RULE15] [RULE17] [RULE22]
      if (monitor) head_last_reg <= bus.headroom;
      pull_reg     <= head_event;                                   // [RULE15] [RULE16]
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  toggle_set_a: assert property (clk_en && pwm_change |=> toggle_reg) // [RULE14]
    else $error("toggle flag missed a level change");
  head_pull_a: assert property (clk_en && monitor && bus.headroom |=> pull_reg && head_reg) // [RULE15]
    else $error("headroom event did not pull gate low");
  head_resume_a: assert property (clk_en && !bus.headroom |=> !pull_reg) // [RULE16]
    else $error("gate stays pulled low after headroom recovered");
  lat_copy_a: assert property (clk_en && lat_upd && !lat_clr |=> latched_reg == $past(live_reg)) // [RULE9]
    else $error("latched flag not copied from live flag");
  live_fall_a: assert property (clk_en && pwm_fall && !live_set |=> !live_reg) // [RULE19]
    else $error("live flag not cleared on pwm fall");

endmodule
`default_nettype wire

// ### src/ldd_diag_flags.sv
// Diagnostic flag bank of a three-channel LED buck driver
//
// Notes on behaviour
// RULE1 - Overtemperature sets its flag, shuts gate driver and supply, stops output current.
// RULE2 - Overtemperature while gate supply is good also sets the gate supply fault.
// RULE3 - Clear-faults clears overtemp only when cool; its companion fault clears with it.
// RULE4 - Gate supply fault after 12 ms failure at start-up, 1 ms when running.
// RULE5 - Gate supply fault shuts gate driver and regulator, clears good, stops current.
// RULE6 - While gate supply fault is set, LED voltage results stop updating.
// RULE7 - Gate supply fault clears on clear-faults, chip disable, or power-on reset.
// RULE8 - Gate supply good follows regulation; cleared on undervoltage or supply error.
// RULE9 - Latched reached flag updates on pwm falling edge or update request.
// RULE10 - Latched reached flag clears on undervoltage or headroom event on that channel.
// RULE11 - Update request copies live into latched, clears live, then self-clears.
// RULE12 - Nvm rejected flag sets on refused write, clears on write to its register.
// RULE13 - Nvm done flag sets on finished accepted access, clears on register write.
// RULE14 - Toggle flag sets on any pwm level change, clears on register write.
// RULE15 - Headroom too low while channel on and supply ok pulls gate low, sets flag.
// RULE16 - Switching resumes once headroom is above threshold again.
// RULE17 - Headroom flags stay until written; may reassert from last sample when off.
// RULE18 - Live reached flag sets once target current is reached in the pwm cycle.
// RULE19 - Live flag clears on pwm fall, undervoltage, update request, 1 ms gate-high.
// RULE20 - Headroom register: live flags at bits 5:3, headroom at 2:0, 7:6 zero.
// RULE21 - Toggle register: toggles at bits 2:0, bit 7 reads zero, bit 6 one.
// RULE22 - A setting event beats a coincident clearing write.
`timescale 1ns/1ps
`default_nettype none
module ldd_diag_flags
  import ldd_pkg::*;
#(
  parameter int START_LIM = START_CYC,
  parameter int RUN_LIM   = RUN_CYC,
  parameter int GATE_LIM  = GATE_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       chip_enable,
  input  wire logic       overtemp_cmp,
  input  wire logic       gate_supply_regulated,
  input  wire logic       supply_above_uv_in,
  input  wire logic [2:0] pwm_pin,
  input  wire logic [2:0] target_reached_cmp,
  input  wire logic [2:0] headroom_low_cmp,
  input  wire logic [2:0] gate_high,
  input  wire logic [2:0] chan_on,
  input  wire logic       clear_faults,
  input  wire logic       nvm_reject,
  input  wire logic       nvm_done,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [6:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            overtemp_flag,
  output logic            gate_supply_fault,
  output logic            gate_supply_good,
  output logic            supply_above_uv,
  output logic            gate_driver_en,
  output logic            gate_supply_reg_en,
  output logic            vled_update_en,
  output logic      [2:0] latched_reached,
  output logic      [2:0] gate_pull_low
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic addr_hit(input logic [6:0] a, input logic [6:0] off);
    addr_hit = (a == off);
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int SYNC_W = 13;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;

  // Enable, pwm and comparator inputs cross two flops before use; gate_high and chan_on do not
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else if (clk_en) begin
      sync1_reg <= {chip_enable, overtemp_cmp, gate_supply_regulated, supply_above_uv_in,
                    pwm_pin, target_reached_cmp, headroom_low_cmp};
      sync2_reg <= sync1_reg;
    end
  end

  wire       en_s   = sync2_reg[12];
  wire       ot_s   = sync2_reg[11];
  wire       reg_s  = sync2_reg[10];
  wire       uv_ok  = sync2_reg[9];
  wire [2:0] pwm_s  = sync2_reg[8:6];
  wire [2:0] rch_s  = sync2_reg[5:3];
  wire [2:0] head_s = sync2_reg[2:0];

  // ****************************************
  // Register access decode
  // ****************************************
  wire wr_req  = reg_wr & addr_hit(reg_addr, ADDR_UPD_REQ);
  wire wr_head = reg_wr & addr_hit(reg_addr, ADDR_HEAD_LIVE);
  wire wr_tog  = reg_wr & addr_hit(reg_addr, ADDR_TOG_NVM);

  logic [2:0] req_reg;
  logic       nvm_rej_reg;
  logic       nvm_done_reg;
  logic [7:0] rdata_reg;
  logic       uv_ok_reg;

  // ****************************************
  // Gate-drive supply and temperature
  // ****************************************
  ldd_gs_e          gs_reg;
  ldd_gs_e          gs_next;
  logic             ot_reg;
  logic             ot_fault_reg;
  logic [TMR_W-1:0] tmr_reg;
  logic             drv_en_reg;
  logic             reg_en_reg;

  // Overtemperature may only be cleared once the die is cool again
  wire ot_clr    = clear_faults & ~ot_s;                             // [RULE3]
  // On clear-faults, a fault born with overtemperature leaves only together with it
  wire fault_clr = clear_faults & ~(ot_fault_reg & ot_s);            // [RULE3] [RULE7]
  wire run_ok    = en_s & uv_ok & ~ot_s & ~ot_reg;
  wire tmr_start = tmr_reg >= TMR_W'(START_LIM - 1);                 // [RULE4]
  wire tmr_run   = tmr_reg >= TMR_W'(RUN_LIM - 1);                   // [RULE4]
  wire ot_on_good = ot_s & (gs_reg == GS_GOOD);                      // [RULE2]

  // Supply sequencing; the fault state is sticky until cleared
  always_comb begin
    gs_next = gs_reg;
    case (gs_reg)
      GS_OFF: begin
        if (run_ok) gs_next = GS_START;
      end
      GS_START: begin
        if (!run_ok) gs_next = GS_OFF;                               // [RULE1] [RULE8]
        else if (reg_s) gs_next = GS_GOOD;                           // [RULE8]
        else if (tmr_start) gs_next = GS_FAULT;                      // [RULE4]
      end
      GS_GOOD: begin
        if (ot_on_good) gs_next = GS_FAULT;                          // [RULE2]
        else if (!run_ok) gs_next = GS_OFF;                          // [RULE8]
        else if (!reg_s) gs_next = GS_SAG;
      end
      GS_SAG: begin
        if (!run_ok) gs_next = GS_OFF;
        else if (reg_s) gs_next = GS_GOOD;
        else if (tmr_run) gs_next = GS_FAULT;                        // [RULE4]
      end
      GS_FAULT: begin
        if (fault_clr) gs_next = GS_OFF;                             // [RULE7]
      end
      default: gs_next = GS_OFF;
    endcase
    // Off mode wipes the fault regardless of state
    if (!en_s) gs_next = GS_OFF;                                     // [RULE7]
  end

  // State, failure timer and driver enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gs_reg     <= GS_OFF;
      tmr_reg    <= TMR_RST;
      drv_en_reg <= 1'b0;
      reg_en_reg <= 1'b0;
    end else if (clk_en) begin
      gs_reg     <= gs_next;
      tmr_reg    <= (gs_next != gs_reg) ? TMR_RST : tmr_reg + 1'b1;
      drv_en_reg <= (gs_next == GS_GOOD);                            // [RULE1] [RULE5]
      reg_en_reg <= (gs_next == GS_START) || (gs_next == GS_GOOD) ||
                    (gs_next == GS_SAG);                             // [RULE1] [RULE5]
    end
  end

  // Overtemperature flag and the fault it spawned; set beats clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ot_reg       <= 1'b0;
      ot_fault_reg <= 1'b0;
    end else if (clk_en) begin
      ot_reg <= ot_s | (ot_reg & ~ot_clr);                           // [RULE1] [RULE3] [RULE22]
      if (ot_on_good) ot_fault_reg <= 1'b1;                          // [RULE2]
      else if (gs_next != GS_FAULT) ot_fault_reg <= 1'b0;
    end
  end

  // ****************************************
  // Software-visible flags
  // ****************************************
  // Update requests live one cycle, so a read mostly sees zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_reg      <= CH_FLAGS_RST;
      nvm_rej_reg  <= 1'b0;
      nvm_done_reg <= 1'b0;
      uv_ok_reg    <= 1'b0;
    end else if (clk_en) begin
      req_reg      <= wr_req ? reg_wdata[2:0] : CH_FLAGS_RST;        // [RULE11]
      nvm_rej_reg  <= nvm_reject | (nvm_rej_reg & ~wr_tog);          // [RULE12] [RULE22]
      nvm_done_reg <= nvm_done | (nvm_done_reg & ~wr_tog);           // [RULE13] [RULE22]
      uv_ok_reg    <= uv_ok;
    end
  end

  // ****************************************
  // Channel slices
  // ****************************************
  ldd_chan_if ch_if [NCH] ();
  logic [2:0] toggle_w;
  logic [2:0] live_w;
  logic [2:0] latched_w;
  logic [2:0] lowhead_w;
  logic [2:0] pull_w;

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    assign ch_if[i].pwm       = pwm_s[i];
    assign ch_if[i].reached   = rch_s[i];
    assign ch_if[i].headroom  = head_s[i];
    assign ch_if[i].gate_high = gate_high[i];
    assign ch_if[i].chan_on   = chan_on[i];
    assign ch_if[i].uv_ok     = uv_ok;
    assign ch_if[i].req       = req_reg[i];
    assign ch_if[i].clr_head  = wr_head;
    assign ch_if[i].clr_tog   = wr_tog;
    assign toggle_w[i]        = ch_if[i].toggle;
    assign live_w[i]          = ch_if[i].live;
    assign latched_w[i]       = ch_if[i].latched;
    assign lowhead_w[i]       = ch_if[i].lowhead;
    assign pull_w[i]          = ch_if[i].pull_low;

    ldd_chan #(
      .GATE_LIM (GATE_LIM)
    ) u_chan (
      .clk    (clk),
      .rst_n  (rst_n),
      .clk_en (clk_en),
      .bus    (ch_if[i])
    );
  end

  // ****************************************
  // Read mux
  // ****************************************
  wire [7:0] rd_req  = {5'h00, req_reg};
  wire [7:0] rd_head = {2'h0, live_w, lowhead_w};                    // [RULE20]
  wire [7:0] rd_tog  = {1'b0, 1'b1, 1'b0, nvm_rej_reg, nvm_done_reg, toggle_w}; // [RULE21]
  wire [7:0] rd_mux  = addr_hit(reg_addr, ADDR_UPD_REQ)   ? rd_req  :
                       addr_hit(reg_addr, ADDR_HEAD_LIVE) ? rd_head :
                       addr_hit(reg_addr, ADDR_TOG_NVM)   ? rd_tog  : RDATA_RST;

  // Read data registered; unmapped offsets read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= RDATA_RST;
    end else if (clk_en && reg_rd) begin
      rdata_reg <= rd_mux;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata          = rdata_reg;
  assign overtemp_flag      = ot_reg;
  assign gate_supply_fault  = (gs_reg == GS_FAULT);                  // [RULE5]
  assign gate_supply_good   = (gs_reg == GS_GOOD);                   // [RULE8]
  assign supply_above_uv    = uv_ok_reg;
  assign gate_driver_en     = drv_en_reg;
  assign gate_supply_reg_en = reg_en_reg;
  // Good already excludes fault, so measurement freezes on a fault
  assign vled_update_en     = (gs_reg == GS_GOOD);                   // [RULE6]
  assign latched_reached    = latched_w;
  assign gate_pull_low      = pull_w;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_sag_expire;
    clk_en && gs_reg == GS_SAG && run_ok && !reg_s && tmr_run;
  endsequence
  sequence s_fault_held;
    gs_reg == GS_FAULT && !drv_en_reg;
  endsequence

  ot_set_a: assert property (clk_en && ot_s |=> ot_reg && !drv_en_reg) // [RULE1]
    else $error("overtemperature did not set flag or stop driver");
  ot_fault_a: assert property (clk_en && en_s && ot_on_good |=> gate_supply_fault) // [RULE2]
    else $error("overtemperature on good supply did not raise fault");
  ot_hold_a: assert property (clk_en && ot_reg && ot_s |=> ot_reg) // [RULE3]
    else $error("overtemperature flag cleared while still hot");
  sag_fault_a: assert property ((s_sag_expire and en_s) |=> s_fault_held) // [RULE4]
    else $error("supply failure timer did not raise fault");
  fault_off_a: assert property (gate_supply_fault |-> !gate_supply_good && !vled_update_en) // [RULE5]
    else $error("fault coexists with good supply or measurement");
  dis_clear_a: assert property (clk_en && !en_s |=> !gate_supply_fault && !reg_en_reg) // [RULE7]
    else $error("chip disable did not clear supply fault");
  req_self_a: assert property (clk_en && req_reg != 3'h0 && !wr_req |=> req_reg == 3'h0) // [RULE11]
    else $error("update request did not self-clear");
  nvm_clr_a: assert property (clk_en && wr_tog && !nvm_reject |=> !nvm_rej_reg) // [RULE12]
    else $error("nvm rejected flag not cleared by write");
  nvm_win_a: assert property (clk_en && wr_tog && nvm_done |=> nvm_done_reg) // [RULE22]
    else $error("nvm done lost against clearing write");
  rd_rsvd_a: assert property (clk_en && reg_rd && addr_hit(reg_addr, ADDR_TOG_NVM)
                              |=> reg_rdata[7:5] == 3'b010) // [RULE21]
    else $error("reserved bits of toggle register wrong");

endmodule
`default_nettype wire

// ### verification/ldd_mcu_model.sv
// Controller-side model issuing byte register accesses to the flag bank
`timescale 1ns/1ps
`default_nettype none
module ldd_mcu_model (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [6:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  // Idle bus at time zero
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 7'h00;
    reg_wdata = 8'h00;
  end
  // One strobe cycle; released data is inverted so stale values never look valid
  task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    reg_wr    <= wr;
    reg_rd    <= ~wr;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    reg_wdata <= ~d;
    @(posedge clk);
    q = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ### verification/led_driver_diagnostic_flags_tb.sv
// Self-checking bench for the LED driver diagnostic flag bank
`timescale 1ns/1ps
`default_nettype none
module led_driver_diagnostic_flags_tb;
  import ldd_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, en = 1'b0, hot = 1'b0, regd = 1'b0, uv_in = 1'b1, clr = 1'b0;
  logic nrej = 1'b0, ndone = 1'b0, wr, rd;
  logic [2:0] pwm = 3'h0, rch = 3'h0, hd = 3'h0, con = 3'h0, gh = 3'h0, latched, pull;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, q;
  logic ot, gf, gg, uvs, gde, gre, vle;
  int bad_count = 0, cmp_count = 0, cycles = 0, i;
  // ****************************************
  // Clock, instances and hang guard
  // ****************************************
  always #12.5 clk = ~clk;
  ldd_diag_flags #(.START_LIM(40), .RUN_LIM(10), .GATE_LIM(10)) i_ldd_diag_flags (.clk(clk), .rst_n(rst_n),
    .clk_en(1'b1), .chip_enable(en), .overtemp_cmp(hot), .gate_supply_regulated(regd), .supply_above_uv_in(uv_in),
    .pwm_pin(pwm), .target_reached_cmp(rch), .headroom_low_cmp(hd), .gate_high(gh), .chan_on(con),
    .clear_faults(clr), .nvm_reject(nrej), .nvm_done(ndone), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .overtemp_flag(ot), .gate_supply_fault(gf), .gate_supply_good(gg),
    .supply_above_uv(uvs), .gate_driver_en(gde), .gate_supply_reg_en(gre), .vled_update_en(vle),
    .latched_reached(latched), .gate_pull_low(pull));
  ldd_mcu_model i_ldd_mcu_model (.clk(clk), .reg_rdata(rdata), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
    .reg_wdata(wdata));
  // Ceiling far above the few hundred cycles the scenarios need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      give_verdict();
    end
  end
  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      $display("BAD %0t %s got %h", $time, m, got);
      bad_count++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e, input string m);
    i_ldd_mcu_model.access(1'b0, a, 8'h00, q);
    chk(q, e, m);
  endtask
  task automatic wrreg(input logic [6:0] a, input logic [7:0] d);
    i_ldd_mcu_model.access(1'b1, a, d, q);
  endtask
  task automatic give_verdict;
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    rdchk(ADDR_HEAD_LIVE, 8'h00, "headroom reg reset");
    rdchk(ADDR_TOG_NVM, 8'h40, "toggle reg reset");
    rdchk(ADDR_UPD_REQ, 8'h00, "request reg idle");
    rdchk(7'h10, 8'h00, "unmapped read");
  endtask
  task automatic t_toggle_nvm;
    @(posedge clk) pwm <= 3'h2;
    @(posedge clk) nrej <= 1'b1;
    @(posedge clk) {nrej, ndone} <= 2'b01;
    @(posedge clk) ndone <= 1'b0;
    cyc(4);
    rdchk(ADDR_TOG_NVM, 8'h5A, "toggle and nvm set");
    wrreg(ADDR_TOG_NVM, 8'h00);
    rdchk(ADDR_TOG_NVM, 8'h40, "toggle and nvm cleared");
  endtask
  task automatic t_live;
    @(posedge clk) {pwm[0], rch[0]} <= 2'b11;
    cyc(5);
    @(posedge clk) rch[0] <= 1'b0;
    rdchk(ADDR_HEAD_LIVE, 8'h08, "live ch1 set");
    @(posedge clk) pwm[0] <= 1'b0;
    cyc(5);
    chk(latched, 3'h1, "latched on pwm fall");
    rdchk(ADDR_HEAD_LIVE, 8'h00, "live cleared on fall");
  endtask
  task automatic t_gate;
    @(posedge clk) {pwm[1], rch[1]} <= 2'b11;
    cyc(5);
    @(posedge clk) rch[1] <= 1'b0;
    rdchk(ADDR_HEAD_LIVE, 8'h10, "live ch2 set");
    @(posedge clk) gh[1] <= 1'b1;
    cyc(12);
    rdchk(ADDR_HEAD_LIVE, 8'h00, "live cleared by gate-high timeout");
  endtask
  task automatic t_update;
    @(posedge clk) {pwm[2], rch[2]} <= 2'b11;
    cyc(5);
    @(posedge clk) rch[2] <= 1'b0;
    cyc(4);
    wrreg(ADDR_UPD_REQ, 8'hFC);
    cyc(1); // Copy lands on the edge the access returns at
    chk(latched, 3'h5, "latched by request");
    rdchk(ADDR_HEAD_LIVE, 8'h00, "live cleared by request");
    rdchk(ADDR_UPD_REQ, 8'h00, "request self-cleared");
  endtask
  task automatic t_headroom;
    @(posedge clk) {con[0], hd[0]} <= 2'b11;
    cyc(5);
    chk(pull, 3'h1, "gate pulled low");
    chk(latched, 3'h4, "latched cleared by headroom");
    @(posedge clk) hd[0] <= 1'b0;
    cyc(5);
    chk(pull, 3'h0, "switching resumed");
    rdchk(ADDR_HEAD_LIVE, 8'h01, "headroom flag kept");
    wrreg(ADDR_HEAD_LIVE, 8'h00);
    rdchk(ADDR_HEAD_LIVE, 8'h00, "headroom flag cleared");
  endtask
  task automatic pulse_clear;
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    cyc(2);
  endtask
  task automatic t_supply;
    @(posedge clk) {en, regd} <= 2'b11;
    for (i = 0; i < 100 && gg !== 1'b1; i++) @(posedge clk);
    chk({gg, vle, gde, gre}, 4'hF, "supply good");
    @(posedge clk) hot <= 1'b1;
    cyc(5);
    chk({ot, gf, gg, gde, gre, vle}, 6'h30, "overtemp shutdown");
    pulse_clear();
    chk({ot, gf}, 2'h3, "no clear while hot");
    @(posedge clk) hot <= 1'b0;
    cyc(5);
    pulse_clear();
    chk({ot, gf}, 2'h0, "cleared when cool");
    for (i = 0; i < 100 && gg !== 1'b1; i++) @(posedge clk);
    @(posedge clk) regd <= 1'b0;
    for (i = 0; i < 100 && gf !== 1'b1; i++) @(posedge clk);
    chk({i >= 10, i < 40, gf, gg, vle}, 5'h1C, "running supply failure fault");
    @(posedge clk) regd <= 1'b1;
    pulse_clear();
    chk(gf, 1'b0, "clear-faults clears supply fault");
    for (i = 0; i < 100 && gg !== 1'b1; i++) @(posedge clk);
    @(posedge clk) uv_in <= 1'b0;
    cyc(5);
    chk({uvs, gg, gf}, 3'h0, "undervoltage drops good");
    chk(latched, 3'h0, "undervoltage clears latched");
    @(posedge clk) {uv_in, regd} <= 2'b10;
    for (i = 0; i < 100 && gf !== 1'b1; i++) @(posedge clk);
    chk({i >= 40, gf, vle, gde}, 4'hC, "start-up failure fault");
    @(posedge clk) en <= 1'b0;
    cyc(5);
    chk(gf, 1'b0, "off mode clears fault");
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    cyc(5);
    @(posedge clk) rst_n <= 1'b1;
    t_regs();
    t_toggle_nvm();
    t_live();
    t_gate();
    t_update();
    t_headroom();
    t_supply();
    give_verdict();
  end
endmodule
`default_nettype wire
